/* core/swd_pkg.sv */
package swd_pkg;

  // Core clock and internal time base.
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_US = 100;
  localparam int TICK_CYC = (TICK_US * 1000 + CLK_PERIOD_NS - 1) /
                            CLK_PERIOD_NS;
  localparam int TW = 21;
  localparam int FRAME_BITS = 16;

  // Times in their own units, as printed or as chosen.
  localparam int RST_PULSE_US = 1000;
  localparam int RST_TICKS = (RST_PULSE_US + TICK_US - 1) / TICK_US;
  localparam int NREQ_LONG_MS = 256;
  localparam int NREQ_SHORT_MS [4] = '{8, 16, 32, 64};
  localparam int WD_PERIOD_MS [4] = '{10, 50, 100, 350};
  localparam int FLASH_PERIOD_MS [4] = '{4000, 8000, 16000, 32000};

  // Converts milliseconds into time-base ticks.
  function automatic logic [TW-1:0] ms_ticks(input int ms);
    return TW'(ms * 1000 / TICK_US);
  endfunction

  // Command opcodes, high byte of each 16-bit frame.
  localparam logic [7:0] OP_REFRESH = 8'h5A;
  localparam logic [7:0] OP_RND_READ = 8'h1B;
  localparam logic [7:0] OP_WDCFG = 8'h1A;
  localparam logic [7:0] OP_PERIOD = 8'h1C;
  localparam logic [7:0] OP_NREQCFG = 8'h1D;
  localparam logic [7:0] OP_DEBUG_EXIT = 8'h1E;
  localparam logic [7:0] OP_INT_READ = 8'h1F;
  localparam logic [7:0] OP_SEC_REQ = 8'h2A;
  localparam logic [7:0] OP_SEC_INIT = 8'h30;
  localparam logic [7:0] OP_SEC_FLASH = 8'h31;
  localparam logic [7:0] OP_SEC_RESET = 8'h32;
  localparam logic [7:0] OP_FLASH_EXIT = 8'h33;
  localparam logic [7:0] DATA_ZERO = 8'h00;

  // Configuration-mode watchdog register fields, then the flash field of the period command.
  localparam int CFG_RETAIN_BIT = 0;
  localparam int CFG_WIN_BIT = 1;
  localparam int CFG_CNT_LSB = 2;
  localparam int CFG_FLASH_INT_BIT = 4;
  localparam int CFG_INTCHK_BIT = 7;
  localparam int PER_FLASH_LSB = 4;

  localparam logic [1:0] ADV_OFF = 2'h0;
  localparam logic [1:0] ADV_1 = 2'h1;
  localparam logic [1:0] ADV_2 = 2'h2;
  localparam logic [1:0] ADV_4 = 2'h3;
  localparam logic [7:0] MASK_1 = 8'hFF;
  localparam logic [7:0] MASK_2 = 8'hF0;
  localparam logic [7:0] MASK_4 = 8'hC0;
  localparam logic [1:0] DEF_PERIOD_SEL = 2'h3;

  // Random code generator; seed value is arbitrary.
  localparam logic [7:0] LFSR_SEED = 8'hA5;
  localparam logic [7:0] LFSR_TAPS = 8'hB8;

  typedef enum logic [2:0] {
    MD_INIT, MD_RESET, MD_NREQ, MD_NORMAL, MD_FLASH, MD_LP_ON
  } swd_mode_t;

  typedef struct packed {
    logic [7:0] op;
    logic [7:0] data;
  } swd_cmd_t;

  typedef struct packed {
    logic int_chk;
    logic flash_int;
    logic [1:0] adv_cnt;
    logic win_sel;
    logic retain;
  } swd_cfg_t;

  localparam swd_cfg_t CFG_RST = '{int_chk: 1'b0, flash_int: 1'b0,
                                   adv_cnt: ADV_OFF, win_sel: 1'b1,
                                   retain: 1'b0};

endpackage

/* core/swd_watchdog.sv */
`timescale 1ns/100ps
module swd_watchdog
  import swd_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  input wire logic debug_entry_pin_in,
  input wire logic batfail_in,
  input wire logic int_event_in,
  input wire logic lp_enter_in,
  input wire logic lp_wake_in,
  output logic miso_out,
  output logic rst_n_out,
  output logic int_pulse_out,
  output logic debug_out,
  output swd_mode_t mode_out,
  output logic [7:0] random_code_out
);

  localparam int PW = $clog2(TICK_CYCLES + 1);
  localparam int BW = $clog2(FRAME_BITS);

  // ---------------- Link side, on the serial clock ----------------
  logic [1:0] lrst_q;
  logic [BW-1:0] bit_r;
  logic [FRAME_BITS-1:0] sh_r;
  logic [FRAME_BITS-1:0] tx_r;
  logic [FRAME_BITS-1:0] rx_word_r;
  logic rx_tgl_r;
  logic miso_r;
  logic [FRAME_BITS-1:0] resp_word_r;

  // Reset brought into the link domain through two flops.
  always_ff @(posedge sclk_in) begin
    lrst_q <= {lrst_q[0], resetn_in};
  end

  // Shifts MOSI in and hands each full word over with a toggle.
  always_ff @(posedge sclk_in) begin
    if (!lrst_q[1]) begin
      bit_r <= '0;
      sh_r <= '0;
      rx_word_r <= '0;
      rx_tgl_r <= 1'b0;
    end else if (!cs_n_in) begin
      sh_r <= {sh_r[FRAME_BITS-2:0], mosi_in};
      if (bit_r == BW'(FRAME_BITS - 1)) begin
        bit_r <= '0;
        rx_word_r <= {sh_r[FRAME_BITS-2:0], mosi_in};
        rx_tgl_r <= ~rx_tgl_r;
      end else begin
        bit_r <= bit_r + 1'b1;
      end
    end
  end

  // Response word is quiet between frames, so it is loaded at bit zero.
  always_ff @(posedge sclk_in) begin
    if (!lrst_q[1]) begin
      tx_r <= '0;
      miso_r <= 1'b0;
    end else if (!cs_n_in) begin
      if (bit_r == '0) begin
        miso_r <= resp_word_r[FRAME_BITS-1];
        tx_r <= {resp_word_r[FRAME_BITS-2:0], 1'b0};
      end else begin
        miso_r <= tx_r[FRAME_BITS-1];
        tx_r <= {tx_r[FRAME_BITS-2:0], 1'b0};
      end
    end
  end

  assign miso_out = miso_r;

  // ---------------- Core side, on the reference clock ----------------
  logic [2:0] tgl_q;
  logic [1:0] pin_q;
  swd_cmd_t cmd_r;
  logic cmd_v_r;
  logic [PW-1:0] pre_r;
  logic tick_r;
  swd_mode_t state_r;
  swd_mode_t state_nxt;
  logic [TW-1:0] cnt_r;
  logic [TW-1:0] int_cnt_r;
  swd_cfg_t cfg_r;
  logic [1:0] per_sel_r;
  logic [1:0] flash_sel_r;
  logic [1:0] short_sel_r;
  logic short_en_r;
  logic use_short_r;
  logic unlock_r;
  logic debug_r;
  logic sec_pend_r;
  logic int_wait_r;
  logic [1:0] step_r;
  logic [7:0] lfsr_r;
  logic [7:0] code_r;
  logic rst_n_r;
  logic int_pulse_r;

  // Word toggle and debug pin both pass two flops first.
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      tgl_q <= '0;
      pin_q <= '0;
    end else begin
      tgl_q <= {tgl_q[1:0], rx_tgl_r};
      pin_q <= {pin_q[0], debug_entry_pin_in};
    end
  end

  // Captures a received word; the link word is stable by now.
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      cmd_r <= '0;
      cmd_v_r <= 1'b0;
    end else begin
      cmd_v_r <= tgl_q[2] ^ tgl_q[1];
      if (tgl_q[2] ^ tgl_q[1]) begin
        cmd_r <= rx_word_r;
      end
    end
  end

  // Time-base prescaler, one tick every TICK_CYCLES cycles.
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      pre_r <= '0;
      tick_r <= 1'b0;
    end else if (pre_r == PW'(TICK_CYCLES - 1)) begin
      pre_r <= '0;
      tick_r <= 1'b1;
    end else begin
      pre_r <= pre_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

  // Decoded command and period view.
  logic [TW-1:0] per;
  logic [TW-1:0] half;
  logic [7:0] mask;
  logic [1:0] last_step;
  logic [7:0] inv_code;
  logic is_ref;
  logic adv;
  logic win_open;
  logic ref_good;
  logic ref_bad;
  logic ref_part;
  logic expire;
  logic int_late;
  logic pin_drop;
  logic sec_ok;
  logic cfg_wr_ok;
  logic wd_fault;

  always_comb begin
    unique case (state_r)
      MD_NREQ: per = use_short_r ? ms_ticks(NREQ_SHORT_MS[short_sel_r])
                                 : ms_ticks(NREQ_LONG_MS);
      MD_FLASH: per = ms_ticks(FLASH_PERIOD_MS[flash_sel_r]);
      default: per = ms_ticks(WD_PERIOD_MS[per_sel_r]);
    endcase
    half = per >> 1;
    unique case (cfg_r.adv_cnt)
      ADV_2: begin
        mask = MASK_2 >> (4 * step_r);
        last_step = 2'h1;
      end
      ADV_4: begin
        mask = MASK_4 >> (2 * step_r);
        last_step = 2'h3;
      end
      default: begin
        mask = MASK_1;
        last_step = 2'h0;
      end
    endcase
  end

  always_comb begin
    inv_code = ~code_r;
    is_ref = cmd_v_r && (cmd_r.op == OP_REFRESH);
    adv = (cfg_r.adv_cnt != ADV_OFF) && (state_r == MD_NORMAL);
    win_open = !cfg_r.win_sel || (cnt_r >= half);
    ref_good = 1'b0;
    ref_bad = 1'b0;
    ref_part = 1'b0;
    if (is_ref && state_r == MD_FLASH) begin
      ref_good = (cmd_r.data == DATA_ZERO);
      ref_bad = !ref_good;
    end else if (is_ref && state_r == MD_NORMAL && !adv) begin
      ref_good = (cmd_r.data == DATA_ZERO) && win_open;
      ref_bad = !ref_good;
    end else if (is_ref && adv) begin
      if (cmd_r.data != (inv_code & mask)) begin
        ref_bad = 1'b1;
      end else if (step_r != last_step) begin
        ref_part = 1'b1;
      end else begin
        ref_good = win_open;
        ref_bad = !win_open;
      end
    end
    expire = tick_r && (cnt_r >= per - 1'b1) &&
             (state_r inside {MD_NREQ, MD_NORMAL, MD_FLASH});
    int_late = int_wait_r && (int_cnt_r >= (per << 1));
    pin_drop = debug_r && !pin_q[1];
    sec_ok = cmd_v_r && sec_pend_r && state_r == MD_NORMAL &&
             cmd_r.data == inv_code;
    cfg_wr_ok = state_r == MD_INIT && (batfail_in || unlock_r);
    wd_fault = expire || ref_bad || int_late;
  end

  // Mode sequencing; debug masks every watchdog fault.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      MD_INIT, MD_NREQ: begin
        if (is_ref && cmd_r.data == DATA_ZERO) begin
          state_nxt = MD_NORMAL;
        end else if (expire && !debug_r) begin
          state_nxt = MD_RESET;
        end
      end
      MD_NORMAL: begin
        if (wd_fault && !debug_r) begin
          state_nxt = MD_RESET;
        end else if (sec_ok && cmd_r.op == OP_SEC_INIT) begin
          state_nxt = MD_INIT;
        end else if (sec_ok && cmd_r.op == OP_SEC_FLASH) begin
          state_nxt = MD_FLASH;
        end else if (sec_ok && cmd_r.op == OP_SEC_RESET) begin
          state_nxt = MD_RESET;
        end else if (lp_enter_in) begin
          state_nxt = MD_LP_ON;
        end
      end
      MD_FLASH: begin
        if (wd_fault && !debug_r) begin
          state_nxt = MD_RESET;
        end else if (cmd_v_r && cmd_r.op == OP_FLASH_EXIT) begin
          state_nxt = MD_RESET;
        end
      end
      MD_RESET: begin
        if (tick_r && cnt_r >= TW'(RST_TICKS - 1)) begin
          state_nxt = MD_NREQ;
        end
      end
      MD_LP_ON: begin
        if (lp_wake_in) begin
          state_nxt = MD_NREQ;
        end
      end
      default: state_nxt = MD_RESET;
    endcase
    if (pin_drop) begin
      state_nxt = MD_RESET;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      state_r <= MD_INIT;
      rst_n_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rst_n_r <= (state_nxt != MD_RESET);
    end
  end

  // Period counter; restarts on mode change, good refresh or debug exit.
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      cnt_r <= '0;
    end else if (state_nxt != state_r || ref_good ||
                 (cmd_v_r && cmd_r.op == OP_DEBUG_EXIT) ||
                 (debug_r && wd_fault)) begin
      cnt_r <= '0;
    end else if (tick_r) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // Configuration-mode watchdog register, locked outside config mode.
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      cfg_r <= CFG_RST;
      unlock_r <= 1'b0;
    end else begin
      if (cmd_v_r && cmd_r.op == OP_WDCFG && cfg_wr_ok) begin
        cfg_r.retain <= cmd_r.data[CFG_RETAIN_BIT];
        cfg_r.win_sel <= cmd_r.data[CFG_WIN_BIT];
        cfg_r.adv_cnt <= cmd_r.data[CFG_CNT_LSB +: 2];
        cfg_r.flash_int <= cmd_r.data[CFG_FLASH_INT_BIT];
        cfg_r.int_chk <= cmd_r.data[CFG_INTCHK_BIT];
      end
      if (state_nxt == MD_INIT && state_r == MD_NORMAL) begin
        unlock_r <= 1'b1;
      end else if (state_r != MD_INIT) begin
        unlock_r <= 1'b0;
      end
    end
  end

  // Period selections and normal request timeout choice.
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      per_sel_r <= DEF_PERIOD_SEL;
      flash_sel_r <= DEF_PERIOD_SEL;
      short_sel_r <= '0;
      short_en_r <= 1'b0;
      use_short_r <= 1'b0;
    end else begin
      if (cmd_v_r && cmd_r.op == OP_PERIOD &&
          state_r inside {MD_INIT, MD_NREQ, MD_NORMAL}) begin
        per_sel_r <= cmd_r.data[1:0];
        flash_sel_r <= cmd_r.data[PER_FLASH_LSB +: 2];
      end else if (state_nxt == MD_LP_ON && !cfg_r.retain) begin
        per_sel_r <= DEF_PERIOD_SEL;
      end
      if (cmd_v_r && cmd_r.op == OP_NREQCFG) begin
        short_sel_r <= cmd_r.data[1:0];
        short_en_r <= cmd_r.data[CFG_CNT_LSB];
      end
      if (state_r == MD_LP_ON && lp_wake_in) begin
        use_short_r <= short_en_r;
      end else if (state_nxt == MD_RESET) begin
        use_short_r <= 1'b0;
      end
      if (batfail_in) begin
        per_sel_r <= DEF_PERIOD_SEL;
        use_short_r <= 1'b0;
      end
    end
  end

  // Debug flag: caught in config mode, left by command or pin.
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      debug_r <= 1'b0;
    end else if (pin_drop || (cmd_v_r && cmd_r.op == OP_DEBUG_EXIT)) begin
      debug_r <= 1'b0;
    end else if (state_r == MD_INIT && pin_q[1]) begin
      debug_r <= 1'b1;
    end
  end

  // Random code: free-running sequence mixed into the code on each secured request and each completed advanced refresh.
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      lfsr_r <= LFSR_SEED;
      code_r <= LFSR_SEED;
    end else begin
      lfsr_r <= {lfsr_r[6:0], ^(lfsr_r & LFSR_TAPS)};
      if ((cmd_v_r && cmd_r.op == OP_SEC_REQ) || (adv && ref_good)) begin
        code_r <= lfsr_r ^ code_r;
      end
    end
  end

  // Secured request pending flag and advanced refresh step.
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      sec_pend_r <= 1'b0;
      step_r <= '0;
    end else begin
      if (cmd_v_r && cmd_r.op == OP_SEC_REQ && state_r == MD_NORMAL) begin
        sec_pend_r <= 1'b1;
      end else if ((cmd_v_r && cmd_r.op != OP_RND_READ) ||
                   state_r != MD_NORMAL) begin
        sec_pend_r <= 1'b0;
      end
      if (ref_part) begin
        step_r <= step_r + 1'b1;
      end else if (ref_good || ref_bad || state_r != MD_NORMAL) begin
        step_r <= '0;
      end
    end
  end

  // Interrupt response check; a new event wins over a same-cycle read.
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      int_wait_r <= 1'b0;
      int_cnt_r <= '0;
    end else if (int_event_in && cfg_r.int_chk) begin
      int_wait_r <= 1'b1;
      int_cnt_r <= '0;
    end else if ((cmd_v_r && cmd_r.op == OP_INT_READ) || int_late) begin
      int_wait_r <= 1'b0;
      int_cnt_r <= '0;
    end else if (int_wait_r && tick_r) begin
      int_cnt_r <= int_cnt_r + 1'b1;
    end
  end

  // Half-period pulse in flash mode.
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      int_pulse_r <= 1'b0;
    end else begin
      int_pulse_r <= state_r == MD_FLASH && cfg_r.flash_int && tick_r &&
                     cnt_r == half - 1'b1;
    end
  end

  // Response word shown on MISO at the next frame.
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      resp_word_r <= '0;
    end else begin
      resp_word_r <= {state_r, debug_r, sec_pend_r, int_wait_r, step_r,
                      code_r};
    end
  end

  assign rst_n_out = rst_n_r;
  assign int_pulse_out = int_pulse_r;
  assign debug_out = debug_r;
  assign mode_out = state_r;
  assign random_code_out = code_r;

endmodule

/* test/swd_checker.sv */
`timescale 1ns/100ps
// Watches the mode, reset and pulse outputs of the watchdog core.
module swd_checker
  import swd_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic rst_n_out,
  input wire logic int_pulse_out,
  input wire logic debug_out,
  input wire swd_mode_t mode_out
);
  localparam int RST_MIN = (RST_TICKS - 1) * TICK_CYCLES;
  localparam int RST_MAX = RST_TICKS * TICK_CYCLES + 2;
  localparam int NREQ_CYC = NREQ_LONG_MS * 1000 / TICK_US * TICK_CYCLES;
  localparam int NREQ_MIN = NREQ_CYC - 2 * TICK_CYCLES;
  localparam int NREQ_MAX = NREQ_CYC + 2 * TICK_CYCLES;
  int rst_cnt_r;
  int nreq_cnt_r;

  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (!resetn_in);

  // Cycles spent in reset mode; the tick phase allows one tick of slack.
  always_ff @(posedge ref_clk_in) begin
    rst_cnt_r <= (resetn_in && mode_out == MD_RESET) ? rst_cnt_r + 1 : 0;
  end

  // Cycles spent in normal request mode.
  always_ff @(posedge ref_clk_in) begin
    nreq_cnt_r <= (resetn_in && mode_out == MD_NREQ) ? nreq_cnt_r + 1 : 0;
  end

  a_reset_pin_low: assert property (
    mode_out == MD_RESET |-> !rst_n_out)
    else $error("reset output high in reset mode");
  a_reset_length: assert property (
    $fell(mode_out == MD_RESET) |-> rst_cnt_r >= RST_MIN &&
    rst_cnt_r <= RST_MAX)
    else $error("reset mode length wrong");
  a_reset_to_nreq: assert property (
    $fell(mode_out == MD_RESET) |-> mode_out == MD_NREQ)
    else $error("reset mode not followed by normal request");
  a_nreq_timeout: assert property (
    $past(mode_out == MD_NREQ) && mode_out == MD_RESET && !debug_out
    |-> nreq_cnt_r >= NREQ_MIN)
    else $error("normal request timed out early");
  a_nreq_bound: assert property (
    !debug_out |-> nreq_cnt_r <= NREQ_MAX)
    else $error("normal request outlived its timeout");
  a_debug_no_reset: assert property (
    debug_out && $past(debug_out) |-> rst_n_out)
    else $error("reset asserted in debug mode");
  a_int_one_cycle: assert property (
    $rose(int_pulse_out) |=> !int_pulse_out)
    else $error("half period pulse longer than one cycle");
  a_int_in_flash: assert property (
    int_pulse_out |-> mode_out == MD_FLASH)
    else $error("half period pulse outside flash mode");

  c_flash: cover property ($rose(mode_out == MD_FLASH));
  c_debug: cover property ($rose(debug_out));
  c_reset_end: cover property ($fell(mode_out == MD_RESET));
endmodule

/* test/swd_spi_host.sv */
`timescale 1ns/100ps
// Host serial master: 16-bit frames, clock idle low between frames.
module swd_spi_host (
  output logic sclk_out,
  output logic cs_n_out,
  output logic mosi_out,
  input wire logic miso_in
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end

  // Clock pulses with the frame deselected, so the link reset clears.
  task automatic idle_clocks(input int n);
    repeat (n) begin
      #24 sclk_out = 1'b1;
      #24 sclk_out = 1'b0;
    end
  endtask

  // Sends one word MSB first; reply bits are taken on falling edges.
  task automatic xfer(input logic [15:0] word, output logic [15:0] resp);
    cs_n_out = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi_out = word[i];
      #24 sclk_out = 1'b1;
      #24 sclk_out = 1'b0;
      resp[i] = miso_in;
    end
    #24 cs_n_out = 1'b1;
    // A released data line shows the inverse of its last bit.
    mosi_out = ~mosi_out;
    #100;
  endtask
endmodule

/* test/swd_watchdog_tb_top.sv */
`timescale 1ns/100ps
module swd_watchdog_tb_top;
  import swd_pkg::*;
  logic clk, rstn, batfail, dbg_pin, sclk, cs_n, mosi, miso;
  logic rst_n, int_p, dbg;
  swd_mode_t mode;
  logic [7:0] code, c0, c1, m;
  logic [15:0] rsp;
  int errors, check_count, cyc, t0;
  logic [1:0] sel [3] = '{ADV_1, ADV_2, ADV_4};
  int cnt [3] = '{1, 2, 4};

  // Core clock, 8 ns period.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  swd_watchdog #(.TICK_CYCLES(10)) dut_u (
    .ref_clk_in(clk), .resetn_in(rstn), .sclk_in(sclk), .cs_n_in(cs_n),
    .mosi_in(mosi), .debug_entry_pin_in(dbg_pin), .batfail_in(batfail),
    .int_event_in(1'b0), .lp_enter_in(1'b0), .lp_wake_in(1'b0),
    .miso_out(miso), .rst_n_out(rst_n), .int_pulse_out(int_p),
    .debug_out(dbg), .mode_out(mode), .random_code_out(code)
  );

  swd_spi_host host_u (
    .sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso)
  );

  task automatic test_done;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk_mode(input string nm, input swd_mode_t e);
    check_count++;
    if (mode !== e) begin
      errors++;
      $display("mismatch %s exp %0d got %0d", nm, e, mode);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s exp %b got %b", nm, e, g);
    end
  endtask

  task automatic cmd(input logic [7:0] op, input logic [7:0] d);
    host_u.xfer({op, d}, rsp);
  endtask

  task automatic wait_mode(input swd_mode_t e, input int lim);
    for (int i = 0; i < lim && mode !== e; i++) @(negedge clk);
  endtask

  task automatic read_code(output logic [7:0] c);
    cmd(OP_RND_READ, DATA_ZERO);
    c = rsp[7:0];
  endtask

  // Secured request: a fresh code, then its inverse as confirmation.
  task automatic secure(input logic [7:0] op);
    logic [7:0] a, b;
    read_code(a);
    cmd(OP_SEC_REQ, DATA_ZERO);
    read_code(b);
    chk_bit("fresh secured code", 1'b1, b !== a);
    cmd(op, ~b);
  endtask

  // Leaves reset mode and refreshes into normal mode.
  task automatic to_normal;
    wait_mode(MD_NREQ, 150);
    cmd(OP_REFRESH, DATA_ZERO);
    chk_mode("refresh to normal", MD_NORMAL);
  endtask

  // Cuts a hung run short.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      errors++;
      test_done();
    end
  end

  initial begin
    rstn = 1'b0;
    batfail = 1'b1;
    dbg_pin = 1'b1;
    fork
      host_u.idle_clocks(2);
      repeat (3) @(negedge clk);
    join
    @(negedge clk) rstn = 1'b1;
    repeat (2) @(negedge clk);
    chk_mode("mode after reset", MD_INIT);
    chk_bit("reset out", 1'b1, rst_n);
    chk_bit("seed code", 1'b1, code === LFSR_SEED);
    // The link reset flops must see the release before the first frame.
    host_u.idle_clocks(2);
    repeat (5) @(negedge clk);
    batfail = 1'b0;
    for (int i = 0; i < 20 && dbg !== 1'b1; i++) @(negedge clk);
    chk_bit("debug flag", 1'b1, dbg);
    cmd(OP_PERIOD, DATA_ZERO);
    cmd(OP_REFRESH, DATA_ZERO);
    chk_mode("init to normal", MD_NORMAL);
    cmd(OP_REFRESH, DATA_ZERO);
    chk_mode("early refresh in debug", MD_NORMAL);
    @(negedge clk) dbg_pin = 1'b0;
    wait_mode(MD_RESET, 20);
    chk_mode("debug pin removed", MD_RESET);
    chk_bit("reset pin", 1'b0, rst_n);
    // Two unanswered normal request periods, the second after a timeout.
    for (int k = 0; k < 2; k++) begin
      wait_mode(MD_NREQ, 150);
      chk_mode("reset ends", MD_NREQ);
      t0 = cyc;
      wait_mode(MD_RESET, 27000);
      chk_bit("nreq timeout", 1'b1, cyc-t0 > 25500 && cyc-t0 < 25700);
    end
    to_normal();
    repeat (600) @(negedge clk);
    cmd(OP_REFRESH, DATA_ZERO);
    chk_mode("refresh in window", MD_NORMAL);
    cmd(OP_REFRESH, DATA_ZERO);
    chk_mode("refresh too early", MD_RESET);
    to_normal();
    t0 = cyc;
    wait_mode(MD_RESET, 1200);
    chk_bit("missed refresh", 1'b1, cyc - t0 > 800);
    to_normal();
    secure(OP_SEC_INIT);
    chk_mode("secured init", MD_INIT);
    // Advanced refresh with one, two and four partial commands.
    for (int k = 0; k < 3; k++) begin
      cmd(OP_WDCFG, {4'h0, sel[k], 2'b00});
      cmd(OP_REFRESH, DATA_ZERO);
      chk_mode("advanced entry", MD_NORMAL);
      read_code(c0);
      for (int j = 0; j < cnt[k]; j++) begin
        m = 8'hFF << (8 - 8 / cnt[k]);
        m = m >> (j * 8 / cnt[k]);
        cmd(OP_REFRESH, ~c0 & m);
      end
      chk_mode("advanced refresh", MD_NORMAL);
      read_code(c1);
      chk_bit("new code", 1'b1, c1 !== c0);
      secure(OP_SEC_INIT);
      chk_mode("back to init", MD_INIT);
    end
    cmd(OP_REFRESH, DATA_ZERO);
    read_code(c0);
    cmd(OP_REFRESH, c0 & 8'hC0);
    chk_mode("wrong code bits", MD_RESET);
    to_normal();
    secure(OP_SEC_FLASH);
    chk_mode("secured flash", MD_FLASH);
    cmd(OP_FLASH_EXIT, DATA_ZERO);
    chk_mode("flash exit", MD_RESET);
    to_normal();
    secure(OP_SEC_RESET);
    chk_mode("secured reset", MD_RESET);
    test_done();
  end
endmodule

bind swd_watchdog swd_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
  .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .rst_n_out(rst_n_out),
  .int_pulse_out(int_pulse_out), .debug_out(debug_out),
  .mode_out(mode_out)
);
